// file: logic/alu_pkg.sv
package alu_pkg;

	// ----------------------------------------------------------------
	// register map (word index on the plain register port)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam logic [5:0] GPR_LAST = 6'h1f; // 0x00..0x1f: working registers
	localparam logic [5:0] REG_FLAGS = 6'h20;
	localparam logic [5:0] REG_PC_LO = 6'h21;
	localparam logic [5:0] REG_PC_HI = 6'h22;
	localparam logic [5:0] REG_DST = 6'h23;
	localparam logic [5:0] REG_SRC = 6'h24;
	localparam logic [5:0] REG_IMM = 6'h25;
	localparam logic [5:0] REG_TGT_LO = 6'h26;
	localparam logic [5:0] REG_TGT_HI = 6'h27;
	localparam logic [5:0] REG_CMD = 6'h28;
	localparam logic [5:0] REG_STAT = 6'h29;

	// status bits
	localparam int STAT_BUSY = 0;
	localparam int STAT_BAD = 1;

	// fixed register indices
	localparam logic [4:0] IDX_PROD_LO = 5'h00;
	localparam logic [4:0] IDX_PROD_HI = 5'h01;
	localparam logic [4:0] IDX_PTR_LO = 5'h1e;
	localparam logic [4:0] IDX_PTR_HI = 5'h1f;

	// reset values and constants
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] SIGN_MIN = 8'h80;
	localparam logic [7:0] SIGN_MAX = 8'h7f;

	// cycle counts
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;

	// ----------------------------------------------------------------
	// operation codes
	// ----------------------------------------------------------------
	localparam logic [4:0] OP_ADD_REG = 5'h00;
	localparam logic [4:0] OP_ADD_CARRY = 5'h01;
	localparam logic [4:0] OP_WORD_IMMEDIATE_ADD = 5'h02;
	localparam logic [4:0] OP_MINUS_REG = 5'h03;
	localparam logic [4:0] OP_IMMEDIATE_MINUS = 5'h04;
	localparam logic [4:0] OP_BORROW_MINUS_REGISTER = 5'h05;
	localparam logic [4:0] OP_IMMEDIATE_BORROW_MINUS = 5'h06;
	localparam logic [4:0] OP_WORD_IMMEDIATE_SUBTRACT = 5'h07;
	localparam logic [4:0] OP_AND_REG = 5'h08;
	localparam logic [4:0] OP_IMMEDIATE_MASK = 5'h09;
	localparam logic [4:0] OP_OR_REG = 5'h0a;
	localparam logic [4:0] OP_IMMEDIATE_MERGE = 5'h0b;
	localparam logic [4:0] OP_EXCLUSIVE_OR = 5'h0c;
	localparam logic [4:0] OP_ONES_INVERT = 5'h0d;
	localparam logic [4:0] OP_TWOS_COMPLEMENT_INVERT = 5'h0e;
	localparam logic [4:0] OP_SET_BITS_MASK = 5'h0f;
	localparam logic [4:0] OP_CLEAR_BITS_MASK = 5'h10;
	localparam logic [4:0] OP_PLUS_ONE = 5'h11;
	localparam logic [4:0] OP_MINUS_ONE = 5'h12;
	localparam logic [4:0] OP_ZERO_MINUS_CHECK = 5'h13;
	localparam logic [4:0] OP_ZERO_REGISTER = 5'h14;
	localparam logic [4:0] OP_ALL_ONES_REGISTER = 5'h15;
	localparam logic [4:0] OP_UNSIGNED_PRODUCT = 5'h16;
	localparam logic [4:0] OP_SIGNED_PRODUCT = 5'h17;
	localparam logic [4:0] OP_MIXED_SIGN_PRODUCT = 5'h18;
	localparam logic [4:0] OP_FRACTIONAL_UNSIGNED_PRODUCT = 5'h19;
	localparam logic [4:0] OP_FRACTIONAL_SIGNED_PRODUCT = 5'h1a;
	localparam logic [4:0] OP_FRACTIONAL_MIXED_PRODUCT = 5'h1b;
	localparam logic [4:0] OP_RELATIVE_JUMP = 5'h1c;
	localparam logic [4:0] OP_INDIRECT_JUMP = 5'h1d;
	localparam logic [4:0] OP_DIRECT_JUMP = 5'h1e;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic i;
		logic t;
		logic h;
		logic s;
		logic v;
		logic n;
		logic z;
		logic c;
	} flags_t;

	typedef struct packed {
		logic [15:0] value;
		logic carry;
	} product_t;

endpackage : alu_pkg

// file: logic/mul_unit.sv
`timescale 1ns/100ps
`default_nettype none
module mul_unit (
	input wire logic [7:0] a, // multiplicand
	input wire logic [7:0] b, // multiplier
	input wire logic a_signed, // treat a as signed
	input wire logic b_signed, // treat b as signed
	input wire logic frac, // fractional: shift product left by one
	output var alu_pkg::product_t prod // product and carry
);
	import alu_pkg::*;

	logic signed [8:0] sa;
	logic signed [8:0] sb;
	logic signed [17:0] full;
	logic [15:0] raw;

	// sign-extend per mode, multiply, shift for fractional forms
	always_comb begin
		sa = $signed({a_signed & a[7], a});
		sb = $signed({b_signed & b[7], b});
		full = sa * sb;
		raw = full[15:0];
		prod.carry = raw[15]; // carry is the top product bit before shift
		prod.value = frac ? {raw[14:0], 1'b0} : raw;
	end

endmodule : mul_unit
`default_nettype wire

// file: logic/alu_core.sv
`timescale 1ns/100ps
`default_nettype none
module alu_core #(
	parameter int PC_W = 16 // program counter width
) (
	input wire logic ref_clk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic [alu_pkg::ADDR_W-1:0] addr, // register index
	input wire logic [7:0] wr_data, // write data
	input wire logic wr_stb, // write strobe
	input wire logic rd_stb, // read strobe
	output logic [7:0] rd_data, // read data, cycle after strobe
	output logic busy, // operation in progress
	output logic [PC_W-1:0] pc, // program counter
	output var alu_pkg::flags_t flags // status flags
);
	import alu_pkg::*;

	// pc registers are byte wide; narrower or wider counters are refused
	if (PC_W < 8 || PC_W > 16) begin : g_pc_w_check
		$error("PC_W must be 8..16");
	end
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} state_t;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] gpr_q [32];
	logic [7:0] gpr_d [32];
	flags_t flags_q, flags_d;
	logic [15:0] pc_q, pc_d;
	logic [4:0] dst_q, dst_d, src_q, src_d, op_q, op_d;
	logic [7:0] imm_q, imm_d;
	logic [15:0] tgt_q, tgt_d;
	logic [1:0] cnt_q, cnt_d;
	logic bad_q, bad_d;
	state_t state_q, state_d;
	logic [7:0] rd_data_q, rd_data_d;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic [1:0] op_cycles(input logic [4:0] op);
		case (op)
			OP_WORD_IMMEDIATE_ADD, OP_WORD_IMMEDIATE_SUBTRACT,
			OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
			OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
			OP_FRACTIONAL_MIXED_PRODUCT, OP_RELATIVE_JUMP,
			OP_INDIRECT_JUMP: op_cycles = CYC_TWO;
			OP_DIRECT_JUMP: op_cycles = CYC_THREE;
			default: op_cycles = CYC_ONE;
		endcase
	endfunction : op_cycles
	function automatic logic op_known(input logic [4:0] op);
		op_known = (op <= OP_DIRECT_JUMP);
	endfunction : op_known
	function automatic logic is_product(input logic [4:0] op);
		is_product = (op >= OP_UNSIGNED_PRODUCT) && (op <= OP_FRACTIONAL_MIXED_PRODUCT);
	endfunction : is_product

	// ----------------------------------------------------------------
	// multiplier
	// ----------------------------------------------------------------
	product_t prod;
	logic mul_a_signed, mul_b_signed, mul_frac;
	// mode lines from the latched operation
	always_comb begin
		mul_a_signed = (op_q == OP_SIGNED_PRODUCT) || (op_q == OP_MIXED_SIGN_PRODUCT) ||
			(op_q == OP_FRACTIONAL_SIGNED_PRODUCT) || (op_q == OP_FRACTIONAL_MIXED_PRODUCT);
		mul_b_signed = (op_q == OP_SIGNED_PRODUCT) || (op_q == OP_FRACTIONAL_SIGNED_PRODUCT);
		mul_frac = (op_q >= OP_FRACTIONAL_UNSIGNED_PRODUCT) &&
			(op_q <= OP_FRACTIONAL_MIXED_PRODUCT);
	end

	mul_unit u_mul (
		.a(gpr_q[dst_q]),
		.b(gpr_q[src_q]),
		.a_signed(mul_a_signed),
		.b_signed(mul_b_signed),
		.frac(mul_frac),
		.prod(prod)
	);

	// ----------------------------------------------------------------
	// execute: result and flags of the latched operation
	// ----------------------------------------------------------------
	logic [7:0] a, b, r8;
	logic [8:0] sum9;
	logic [15:0] w_in, w_out;
	logic [4:0] dst_hi;
	logic wr8, wr16, wr_prod;
	logic arith, sub, cin, keep_z;
	flags_t f_res;
	logic [15:0] pc_res;

	always_comb begin
		a = gpr_q[dst_q];
		dst_hi = 5'(dst_q + 5'h01);
		w_in = {gpr_q[dst_hi], a};
		b = gpr_q[src_q];
		if (op_q == OP_IMMEDIATE_MINUS || op_q == OP_IMMEDIATE_BORROW_MINUS ||
			op_q == OP_IMMEDIATE_MASK || op_q == OP_IMMEDIATE_MERGE ||
			op_q == OP_SET_BITS_MASK) begin
			b = imm_q;
		end
		r8 = a;
		sum9 = 9'h000;
		w_out = w_in;
		{wr8, wr16, wr_prod, arith, sub, cin, keep_z} = 7'h00;
		f_res = flags_q; // flags hold unless a group below updates them
		pc_res = pc_q;
		case (op_q)
			OP_ADD_REG, OP_ADD_CARRY: begin
				cin = (op_q == OP_ADD_CARRY) & flags_q.c;
				sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
				arith = 1'b1;
			end
			OP_MINUS_REG, OP_IMMEDIATE_MINUS, OP_BORROW_MINUS_REGISTER,
			OP_IMMEDIATE_BORROW_MINUS: begin
				cin = ((op_q == OP_BORROW_MINUS_REGISTER) ||
					(op_q == OP_IMMEDIATE_BORROW_MINUS)) & flags_q.c;
				keep_z = cin | (op_q == OP_BORROW_MINUS_REGISTER) |
					(op_q == OP_IMMEDIATE_BORROW_MINUS);
				sum9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
				arith = 1'b1;
				sub = 1'b1;
			end
			OP_TWOS_COMPLEMENT_INVERT: begin
				b = a;
				a = 8'h00;
				sum9 = 9'h000 - {1'b0, b};
				arith = 1'b1;
				sub = 1'b1;
			end
			OP_AND_REG, OP_IMMEDIATE_MASK: r8 = a & b;
			OP_OR_REG, OP_IMMEDIATE_MERGE, OP_SET_BITS_MASK: r8 = a | b;
			OP_EXCLUSIVE_OR: r8 = a ^ b;
			OP_CLEAR_BITS_MASK: r8 = a & (ALL_ONES - imm_q);
			OP_ZERO_MINUS_CHECK: r8 = a & a;
			OP_ZERO_REGISTER: r8 = a ^ a;
			OP_ONES_INVERT: r8 = ALL_ONES - a;
			OP_PLUS_ONE: r8 = 8'(a + 8'h01);
			OP_MINUS_ONE: r8 = 8'(a - 8'h01);
			OP_ALL_ONES_REGISTER: r8 = ALL_ONES;
			OP_WORD_IMMEDIATE_ADD: w_out = 16'(w_in + {8'h00, imm_q});
			OP_WORD_IMMEDIATE_SUBTRACT: w_out = 16'(w_in - {8'h00, imm_q});
			OP_RELATIVE_JUMP: pc_res = 16'(pc_q + tgt_q + 16'h0001);
			OP_INDIRECT_JUMP: pc_res = {gpr_q[IDX_PTR_HI], gpr_q[IDX_PTR_LO]};
			OP_DIRECT_JUMP: pc_res = tgt_q;
			default: r8 = a;
		endcase

		// flag update per operation group
		if (arith) begin
			r8 = sum9[7:0];
			f_res.c = sum9[8];
			f_res.n = r8[7];
			f_res.z = keep_z ? ((r8 == 8'h00) & flags_q.z) : (r8 == 8'h00);
			if (sub) begin
				f_res.h = (~a[3] & b[3]) | (b[3] & r8[3]) | (r8[3] & ~a[3]);
				f_res.v = (a[7] & ~b[7] & ~r8[7]) | (~a[7] & b[7] & r8[7]);
			end else begin
				f_res.h = (a[3] & b[3]) | (b[3] & ~r8[3]) | (~r8[3] & a[3]);
				f_res.v = (a[7] & b[7] & ~r8[7]) | (~a[7] & ~b[7] & r8[7]);
			end
			if (op_q == OP_TWOS_COMPLEMENT_INVERT) begin
				f_res.c = (r8 != 8'h00);
				f_res.v = (r8 == SIGN_MIN);
			end
			wr8 = 1'b1;
		end else if (op_q >= OP_AND_REG && op_q <= OP_ZERO_REGISTER) begin
			f_res.z = (r8 == 8'h00);
			f_res.n = r8[7];
			// logic ops clear overflow; increment and decrement flag the wrap
			f_res.v = ((op_q == OP_PLUS_ONE) && (r8 == SIGN_MIN)) ||
				((op_q == OP_MINUS_ONE) && (r8 == SIGN_MAX));
			f_res.c = f_res.c | (op_q == OP_ONES_INVERT);
			wr8 = (op_q != OP_ZERO_MINUS_CHECK);
		end else if (op_q == OP_ALL_ONES_REGISTER) begin
			wr8 = 1'b1;
		end else if (op_q == OP_WORD_IMMEDIATE_ADD || op_q == OP_WORD_IMMEDIATE_SUBTRACT) begin
			f_res.n = w_out[15];
			f_res.z = (w_out == 16'h0000);
			if (op_q == OP_WORD_IMMEDIATE_ADD) begin
				f_res.v = ~w_in[15] & w_out[15];
				f_res.c = ~w_out[15] & w_in[15];
			end else begin
				f_res.v = w_in[15] & ~w_out[15];
				f_res.c = w_out[15] & ~w_in[15];
			end
			f_res.s = f_res.n ^ f_res.v;
			wr16 = 1'b1;
		end else if (is_product(op_q)) begin
			f_res.c = prod.carry;
			f_res.z = (prod.value == 16'h0000);
			wr_prod = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// sequencing, register port and commit
	// ----------------------------------------------------------------
	logic launch, commit;
	always_comb begin
		launch = wr_stb && (addr == REG_CMD) && (state_q == ST_IDLE) && op_known(wr_data[4:0]);
		commit = (state_q == ST_EXEC) && (cnt_q == CYC_ONE);
		gpr_d = gpr_q;
		{flags_d, pc_d, dst_d, src_d, imm_d} = {flags_q, pc_q, dst_q, src_q, imm_q};
		{tgt_d, op_d, cnt_d, bad_d} = {tgt_q, op_q, cnt_q, bad_q};
		state_d = state_q;
		rd_data_d = 8'h00;

		// operation timing
		case (state_q)
			ST_IDLE: begin
				if (launch) begin
					op_d = wr_data[4:0];
					cnt_d = op_cycles(wr_data[4:0]);
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				cnt_d = 2'(cnt_q - CYC_ONE);
				if (commit) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase

		// software writes are refused while an operation runs
		if (wr_stb && state_q == ST_IDLE) begin
			if (addr <= GPR_LAST) begin
				gpr_d[addr[4:0]] = wr_data;
			end
			case (addr)
				REG_FLAGS: flags_d = flags_t'(wr_data);
				REG_PC_LO: pc_d[7:0] = wr_data;
				REG_PC_HI: pc_d[15:8] = wr_data;
				REG_DST: dst_d = wr_data[4:0];
				REG_SRC: src_d = wr_data[4:0];
				REG_IMM: imm_d = wr_data;
				REG_TGT_LO: tgt_d[7:0] = wr_data;
				REG_TGT_HI: tgt_d[15:8] = wr_data;
				REG_STAT: bad_d = bad_q & ~wr_data[STAT_BAD];
				default: bad_d = bad_d;
			endcase
		end
		// unknown operation codes are flagged; set wins over clear
		if (wr_stb && addr == REG_CMD && !op_known(wr_data[4:0])) begin
			bad_d = 1'b1;
		end

		// result commit on the last cycle
		if (commit) begin
			flags_d = f_res;
			if (wr8) begin
				gpr_d[dst_q] = r8;
			end
			if (wr16) begin
				gpr_d[dst_q] = w_out[7:0];
				gpr_d[dst_hi] = w_out[15:8];
			end
			if (wr_prod) begin
				gpr_d[IDX_PROD_LO] = prod.value[7:0];
				gpr_d[IDX_PROD_HI] = prod.value[15:8];
			end
			pc_d = pc_res; // equals pc_q unless a jump ran
		end
		pc_d = pc_d & 16'((17'h1_0000 >> (16 - PC_W)) - 17'h0_0001);

		// read data stands in the cycle after the strobe
		if (rd_stb) begin
			if (addr <= GPR_LAST) begin
				rd_data_d = gpr_q[addr[4:0]];
			end
			case (addr)
				REG_FLAGS: rd_data_d = flags_q;
				REG_PC_LO: rd_data_d = pc_q[7:0];
				REG_PC_HI: rd_data_d = pc_q[15:8];
				REG_DST: rd_data_d = {3'h0, dst_q};
				REG_SRC: rd_data_d = {3'h0, src_q};
				REG_IMM: rd_data_d = imm_q;
				REG_TGT_LO: rd_data_d = tgt_q[7:0];
				REG_TGT_HI: rd_data_d = tgt_q[15:8];
				REG_CMD: rd_data_d = {3'h0, op_q};
				REG_STAT: rd_data_d = {6'h00, bad_q, state_q == ST_EXEC};
				default: rd_data_d = rd_data_d;
			endcase
		end
	end

	// registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 32; i++) begin
				gpr_q[i] <= 8'h00;
			end
			flags_q <= flags_t'(FLAGS_RST);
			{pc_q, dst_q, src_q, imm_q} <= 34'h0;
			{tgt_q, op_q, cnt_q, bad_q} <= 24'h0;
			state_q <= ST_IDLE;
			rd_data_q <= 8'h00;
		end else begin
			gpr_q <= gpr_d;
			{flags_q, pc_q, dst_q, src_q, imm_q} <= {flags_d, pc_d, dst_d, src_d, imm_d};
			{tgt_q, op_q, cnt_q, bad_q} <= {tgt_d, op_d, cnt_d, bad_d};
			state_q <= state_d;
			rd_data_q <= rd_data_d;
		end
	end

	// outputs straight from flops
	assign rd_data = rd_data_q;
	assign busy = state_q[1]; // exec bit of the one-hot state
	assign pc = pc_q[PC_W-1:0];
	assign flags = flags_q;

endmodule : alu_core
`default_nettype wire

// file: tb/alu_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
module alu_core_checker #(
	parameter int PC_W = 16 // program counter width
) (
	input wire logic ref_clk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic [alu_pkg::ADDR_W-1:0] addr, // register index
	input wire logic [7:0] wr_data, // write data
	input wire logic wr_stb, // write strobe
	input wire logic rd_stb, // read strobe
	input wire logic [7:0] rd_data, // read data
	input wire logic busy, // operation running
	input wire logic [PC_W-1:0] pc, // program counter
	input wire alu_pkg::flags_t flags // status flags
);
	import alu_pkg::*;
	logic go;
	logic [4:0] op;
	// command write that the block accepts
	assign op = wr_data[4:0];
	assign go = wr_stb && !busy && addr == REG_CMD && wr_data <= 8'h1e;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// timing and flag relations
	// ----------------------------------------
	rd_idle_zero_a: assert property (!rd_stb |=> rd_data == 8'h00)
		else $error("read data not zero outside a read");
	one_cycle_a: assert property (
		go && op <= 5'h15 && op != 5'h02 && op != 5'h07 |=> busy ##1 !busy)
		else $error("one-cycle op busy length wrong");
	two_cycle_a: assert property (
		go && (op == 5'h02 || op == 5'h07 || (op >= 5'h16 && op <= 5'h1d))
		|=> busy [*2] ##1 !busy)
		else $error("two-cycle op busy length wrong");
	three_cycle_a: assert property (go && op == 5'h1e |=> busy [*3] ##1 !busy)
		else $error("direct jump busy length wrong");
	logic_keep_a: assert property (
		go && ((op >= 5'h08 && op <= 5'h0c) || (op >= 5'h0f && op <= 5'h14))
		|=> ##1 (flags & 8'hf1) == ($past(flags) & 8'hf1))
		else $error("logic op touched carry, half or sign");
	ones_keep_a: assert property (go && op == 5'h15 |=> ##1 $stable(flags))
		else $error("set-all-ones changed flags");
	jump_keep_a: assert property (go && op >= 5'h1c |=> $stable(flags) [*3])
		else $error("jump changed flags");
	mul_keep_a: assert property (
		go && op >= 5'h16 && op <= 5'h1b |=> ##2 (flags & 8'hfc) == ($past(flags) & 8'hfc))
		else $error("multiply changed flags other than zero and carry");
	word_keep_a: assert property (
		go && (op == 5'h02 || op == 5'h07) |=> ##2 (flags & 8'he0) == ($past(flags) & 8'he0))
		else $error("word op changed half carry");
	pc_source_a: assert property (!$stable(pc) |-> $past(busy) ||
		$past(wr_stb) && ($past(addr) == REG_PC_LO || $past(addr) == REG_PC_HI))
		else $error("pc moved without jump or write");
endmodule : alu_core_checker
bind alu_core alu_core_checker #(.PC_W(PC_W)) i_checker (.ref_clk(ref_clk), .rst_n(rst_n),
	.addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
	.busy(busy), .pc(pc), .flags(flags));
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import alu_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [7:0] rd_data;
	logic busy;
	logic [15:0] pc;
	flags_t flags;
	int num_errors = 0;
	int compares = 0;
	// 4 ns clock
	always #2 ref_clk = ~ref_clk;
	alu_core #(.PC_W(16)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
		.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
		.busy(busy), .pc(pc), .flags(flags));
	// ----------------------------------------
	// bus and compare helpers
	// ----------------------------------------
	task report_and_stop;
		$display("Comparisons %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop
	task check(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task rd_chk(input logic [5:0] a, input logic [7:0] exp, input string name);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1;
		check(name, {8'h00, exp}, {8'h00, rd_data});
	endtask : rd_chk
	// count busy cycles, bounded
	task wait_idle(input logic [15:0] n);
		int cnt;
		cnt = 0;
		#1;
		while (busy === 1'b1 && cnt < 8) begin
			@(posedge ref_clk);
			#1;
			cnt++;
		end
		if (cnt == 8) begin
			num_errors++;
			report_and_stop();
		end
		check("busy cycles", n, 16'(cnt));
	endtask : wait_idle
	task run(input logic [4:0] op, input logic [15:0] n);
		wr(REG_CMD, {3'h0, op});
		wait_idle(n);
	endtask : run
	// r16 destination, r17 source
	task op8(input logic [4:0] op, input logic [7:0] d, s, k, fin, res, fex,
		input int n);
		wr(6'h10, d);
		wr(6'h11, s);
		wr(REG_DST, 8'h10);
		wr(REG_SRC, 8'h11);
		wr(REG_IMM, k);
		wr(REG_FLAGS, fin);
		run(op, 16'(n));
		rd_chk(6'h10, res, "result");
		rd_chk(REG_FLAGS, fex, "flags");
		check("flags port", {8'h00, fex}, {8'h00, flags});
	endtask : op8
	// upper flags preset so only zero and carry may move
	task mul(input logic [4:0] op, input logic [7:0] d, s, input logic [15:0] p,
		input logic z, c);
		op8(op, d, s, 8'h00, 8'h3c, d, {6'h0f, z, c}, 16'h0002);
		rd_chk(6'h00, p[7:0], "product low");
		rd_chk(6'h01, p[15:8], "product high");
	endtask : mul
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		rd_chk(REG_FLAGS, FLAGS_RST, "flags after reset");
		rd_chk(6'h05, 8'h00, "r5 after reset");
		check("pc after reset", 16'h0000, pc);
	endtask : t_reset
	task t_arith;
		op8(OP_ADD_REG, 8'h38, 8'h48, 8'h00, 8'h01, 8'h80, 8'h2c, 1);
		op8(OP_ADD_CARRY, 8'hff, 8'h00, 8'h00, 8'h01, 8'h00, 8'h23, 1);
		op8(OP_MINUS_REG, 8'h00, 8'h01, 8'h00, 8'h00, 8'hff, 8'h25, 1);
		op8(OP_IMMEDIATE_MINUS, 8'h80, 8'h00, 8'h01, 8'h01, 8'h7f, 8'h28, 1);
		op8(OP_BORROW_MINUS_REGISTER, 8'h05, 8'h04, 8'h00, 8'h03, 8'h00, 8'h02, 1);
		op8(OP_IMMEDIATE_BORROW_MINUS, 8'h05, 8'h00, 8'h04, 8'h01, 8'h00, 8'h00, 1);
	endtask : t_arith
	task t_logic;
		op8(OP_AND_REG, 8'hf0, 8'h0f, 8'h00, 8'h09, 8'h00, 8'h03, 1);
		op8(OP_IMMEDIATE_MASK, 8'h8f, 8'h00, 8'hf0, 8'h00, 8'h80, 8'h04, 1);
		op8(OP_OR_REG, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h02, 1);
		op8(OP_IMMEDIATE_MERGE, 8'h01, 8'h00, 8'h80, 8'h00, 8'h81, 8'h04, 1);
		op8(OP_EXCLUSIVE_OR, 8'haa, 8'haa, 8'h00, 8'h00, 8'h00, 8'h02, 1);
		op8(OP_SET_BITS_MASK, 8'h10, 8'h00, 8'h01, 8'h20, 8'h11, 8'h20, 1);
		op8(OP_CLEAR_BITS_MASK, 8'hff, 8'h00, 8'h0f, 8'h00, 8'hf0, 8'h04, 1);
		op8(OP_ZERO_MINUS_CHECK, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h00, 8'h02, 1);
	endtask : t_logic
	task t_unary;
		op8(OP_ONES_INVERT, 8'h00, 8'h00, 8'h00, 8'h08, 8'hff, 8'h05, 1);
		op8(OP_TWOS_COMPLEMENT_INVERT, 8'h80, 8'h00, 8'h00, 8'h20, 8'h80, 8'h0d, 1);
		op8(OP_PLUS_ONE, 8'h7f, 8'h00, 8'h00, 8'h01, 8'h80, 8'h0d, 1);
		op8(OP_MINUS_ONE, 8'h80, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h08, 1);
		op8(OP_ZERO_REGISTER, 8'h5a, 8'h00, 8'h00, 8'h0c, 8'h00, 8'h02, 1);
		op8(OP_ALL_ONES_REGISTER, 8'h00, 8'h00, 8'h00, 8'h2b, 8'hff, 8'h2b, 1);
	endtask : t_unary
	task t_mul;
		mul(OP_UNSIGNED_PRODUCT, 8'hff, 8'hff, 16'hfe01, 1'b0, 1'b1);
		mul(OP_UNSIGNED_PRODUCT, 8'h00, 8'h55, 16'h0000, 1'b1, 1'b0);
		mul(OP_SIGNED_PRODUCT, 8'h80, 8'h80, 16'h4000, 1'b0, 1'b0);
		mul(OP_MIXED_SIGN_PRODUCT, 8'hff, 8'h02, 16'hfffe, 1'b0, 1'b1);
		mul(OP_FRACTIONAL_UNSIGNED_PRODUCT, 8'h80, 8'h80, 16'h8000, 1'b0, 1'b0);
		mul(OP_FRACTIONAL_SIGNED_PRODUCT, 8'hc0, 8'h40, 16'he000, 1'b0, 1'b1);
		mul(OP_FRACTIONAL_MIXED_PRODUCT, 8'hc0, 8'h02, 16'hff00, 1'b0, 1'b1);
	endtask : t_mul
	// pair r25:r24, carry across the byte boundary
	task t_word;
		wr(6'h18, 8'hff);
		wr(6'h19, 8'h7f);
		wr(REG_DST, 8'h18);
		wr(REG_IMM, 8'h01);
		wr(REG_FLAGS, 8'h30);
		run(OP_WORD_IMMEDIATE_ADD, 16'h0002);
		rd_chk(6'h18, 8'h00, "word low");
		rd_chk(6'h19, 8'h80, "word high");
		rd_chk(REG_FLAGS, 8'h2c, "word flags");
		wr(6'h19, 8'h00);
		wr(REG_FLAGS, 8'h00);
		run(OP_WORD_IMMEDIATE_SUBTRACT, 16'h0002);
		rd_chk(6'h18, 8'hff, "word low");
		rd_chk(6'h19, 8'hff, "word high");
		rd_chk(REG_FLAGS, 8'h15, "word flags");
	endtask : t_word
	task t_jump;
		wr(REG_PC_LO, 8'h00);
		wr(REG_PC_HI, 8'h01);
		wr(REG_TGT_LO, 8'hfe);
		wr(REG_TGT_HI, 8'hff);
		wr(REG_FLAGS, 8'h2b);
		run(OP_RELATIVE_JUMP, 16'h0002);
		check("relative pc", 16'h00ff, pc);
		wr(6'h1e, 8'h34);
		wr(6'h1f, 8'h12);
		run(OP_INDIRECT_JUMP, 16'h0002);
		check("indirect pc", 16'h1234, pc);
		wr(REG_TGT_LO, 8'hef);
		wr(REG_TGT_HI, 8'hbe);
		run(OP_DIRECT_JUMP, 16'h0003);
		check("direct pc", 16'hbeef, pc);
		rd_chk(REG_CMD, {3'h0, OP_DIRECT_JUMP}, "last op");
		rd_chk(REG_FLAGS, 8'h2b, "jump flags");
	endtask : t_jump
	// writes during busy, unknown code, unmapped place
	task t_refuse;
		wr(6'h10, 8'h11);
		wr(REG_CMD, {3'h0, OP_DIRECT_JUMP});
		wr(6'h10, 8'h99);
		wait_idle(16'h0001);
		rd_chk(6'h10, 8'h11, "write while busy");
		wr(REG_CMD, 8'h1f);
		rd_chk(REG_STAT, 8'h02, "bad op status");
		wr(REG_STAT, 8'h02);
		rd_chk(REG_STAT, 8'h00, "bad op cleared");
		wr(6'h3f, 8'hff);
		rd_chk(REG_FLAGS, 8'h2b, "flags after unmapped write");
	endtask : t_refuse
	// main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_arith();
		t_logic();
		t_unary();
		t_mul();
		t_word();
		t_jump();
		t_refuse();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
